// ==== design/tcpwm_cfg.svh ====
// Purpose: register offsets, field positions and reset values
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz aclk
// Notes: definitions only
`ifndef TCPWM_CFG_SVH
`define TCPWM_CFG_SVH

`define TC_INSTANCES 4
// per-instance register window: 8 words, instance n at n*0x20
`define TC_STRIDE 32'h0000_0020
`define TC_OFF_CTRL 3'h0
`define TC_OFF_PERIOD 3'h1
`define TC_OFF_COMPARE 3'h2
`define TC_OFF_COUNT 3'h3
`define TC_OFF_CAPTURE 3'h4
`define TC_OFF_DEADBAND 3'h5
// common registers above the instance windows
`define TC_ADDR_IRQ_STATUS 8'h80
`define TC_ADDR_IRQ_MASK 8'h84
`define TC_ADDR_START 8'h88

// ctrl fields
`define CTRL_ENABLE 0
`define CTRL_MODE_LSB 1
`define CTRL_CMP_LSB 3
`define CTRL_CLK_LSB 6
`define CTRL_IRQSEL_LSB 8
`define CTRL_COMP_EN 11
`define CTRL_RESET 32'h0000_0000
`define PERIOD_RESET 16'hFFFF
`define COMPARE_RESET 16'h8000
`define DEADBAND_RESET 8'h00

// interrupt select bits
`define IRQSEL_TC 0
`define IRQSEL_CMP 1
`define IRQSEL_CAP 2

`endif

// ==== design/tc_pkg.sv ====
// Purpose: shared types of the timer block
// Assumes: nothing
// Notes: constants live in tcpwm_cfg.svh
package tc_pkg;
  typedef enum logic [1:0] {
    mode_free,
    mode_one_shot,
    mode_enable_gated
  } count_mode_e;

  typedef enum logic [2:0] {
    cmp_lt,
    cmp_lte,
    cmp_eq,
    cmp_gte,
    cmp_gt
  } cmp_rel_e;

  // first member is the top bit: comp_en is bit 11, enable is bit 0
  typedef struct packed {
    logic comp_en;
    logic [2:0] irq_sel;
    logic [1:0] clk_sel;
    logic [2:0] cmp;
    logic [1:0] mode;
    logic enable;
  } ctrl_s;
endpackage

// ==== design/tc_cfg_if.sv ====
// Purpose: configuration and status bundle between the top and one timer
// Assumes: single aclk domain
// Notes: top drives cfg, timer drives status
`timescale 1ns/1ps
interface tc_cfg_if;
  tc_pkg::ctrl_s ctrl;
  logic start;
  logic [15:0] period;
  logic [15:0] compare;
  logic [7:0] deadband;
  logic [15:0] count;
  logic [15:0] capture;
  logic [2:0] events;
  logic running;
  modport top (output ctrl, start, period, compare, deadband,
               input count, capture, events, running);
  modport timer (input ctrl, start, period, compare, deadband,
                 output count, capture, events, running);
endinterface

// ==== design/tc_timer.sv ====
// Purpose: one 16-bit down-counting timer, counter and pwm channel
// Assumes: pin inputs already synchronised by the top
// Notes: clock sources are one-cycle ticks on aclk
`timescale 1ns/1ps
`include "tcpwm_cfg.svh"
module tc_timer (
  input wire logic aclk,
  input wire logic aresetn,
  tc_cfg_if.timer cfg,
  input wire logic [3:0] clk_ticks,
  input wire logic reset_in,
  input wire logic capture_in,
  input wire logic enable_in,
  input wire logic kill_in,
  output logic cmp_out,
  output logic cmp_n_out,
  output logic tc_out
);
  logic tick;
  logic cmp_hit;
  logic cmp_raw_q;
  logic cap_q;
  logic step;
  logic [7:0] db_cnt;
  logic raw_prev;
  logic tc_now;

  // counting clock chosen from the tick sources, see RULE3
  assign tick = clk_ticks[cfg.ctrl.clk_sel];
  // gated mode only steps while enable is high, see RULE8
  assign step = tick && cfg.running &&
                (cfg.ctrl.mode != tc_pkg::mode_enable_gated || enable_in);
  assign tc_now = step && (cfg.count == 16'h0000);

  // comparator relation, see RULE4
  always_comb begin
    case (tc_pkg::cmp_rel_e'(cfg.ctrl.cmp))
      tc_pkg::cmp_lt: cmp_hit = cfg.count < cfg.compare;
      tc_pkg::cmp_lte: cmp_hit = cfg.count <= cfg.compare;
      tc_pkg::cmp_eq: cmp_hit = cfg.count == cfg.compare;
      tc_pkg::cmp_gte: cmp_hit = cfg.count >= cfg.compare;
      tc_pkg::cmp_gt: cmp_hit = cfg.count > cfg.compare;
      default: cmp_hit = 1'b0;
    endcase
  end

  // down counter with reload on start, reset and terminal count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.count <= `PERIOD_RESET;
      cfg.running <= 1'b0;
    end else if (cfg.start || reset_in) begin
      cfg.count <= cfg.period; // see RULE5
      cfg.running <= cfg.ctrl.enable;
    end else if (!cfg.ctrl.enable) begin
      cfg.running <= 1'b0;
    end else if (tc_now) begin
      cfg.count <= cfg.period; // see RULE5, see RULE14
      // one-shot stops after a full period, see RULE7
      cfg.running <= (cfg.ctrl.mode != tc_pkg::mode_one_shot); // see RULE6
    end else if (step) begin
      cfg.count <= cfg.count - 16'h0001; // see RULE2
    end
  end

  // full 16-bit capture on a rising capture edge, see RULE11
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.capture <= 16'h0000;
      cap_q <= 1'b0;
    end else begin
      cap_q <= capture_in;
      if (capture_in && !cap_q) begin
        cfg.capture <= cfg.count;
      end
    end
  end

  // event pulses: terminal count, compare becoming true, capture, see RULE10
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.events <= 3'h0;
      cmp_raw_q <= 1'b0;
      tc_out <= 1'b0;
    end else begin
      cmp_raw_q <= cmp_hit && cfg.running;
      tc_out <= tc_now; // see RULE14
      cfg.events[`IRQSEL_TC] <= tc_now;
      cfg.events[`IRQSEL_CMP] <= cmp_hit && cfg.running && !cmp_raw_q;
      cfg.events[`IRQSEL_CAP] <= capture_in && !cap_q;
    end
  end

  // deadband: each output turns on only after the gap, see RULE13
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      db_cnt <= 8'h00;
      raw_prev <= 1'b0;
      cmp_out <= 1'b0;
      cmp_n_out <= 1'b0;
    end else begin
      raw_prev <= cmp_raw_q;
      if (kill_in) begin
        cmp_out <= 1'b0; // see RULE12
        cmp_n_out <= 1'b0;
        db_cnt <= cfg.deadband;
      end else if (cmp_raw_q != raw_prev) begin
        cmp_out <= 1'b0;
        cmp_n_out <= 1'b0;
        db_cnt <= cfg.deadband;
      end else if (db_cnt != 8'h00) begin
        db_cnt <= db_cnt - 8'h01;
      end else begin
        cmp_out <= cmp_raw_q; // see RULE9
        cmp_n_out <= !cmp_raw_q && cfg.ctrl.comp_en && cfg.running;
      end
    end
  end
endmodule

// ==== design/sync2.sv ====
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage read only by the second
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // plain double flop; no logic on the first stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== design/tcpwm_top.sv ====
// Purpose: four timer, counter and pwm channels behind an axi4-lite slave
// Assumes: 20 MHz aclk, synchronous active-low aresetn, routed pins asynchronous
// Notes: channel n owns the words from n*0x20: ctrl, period, compare,
//   count, capture and deadband; irq status, irq mask and start sit at
//   0x80, 0x84 and 0x88; pins are levels, clock and capture act on edges;
//   tc_out and a kill lag their cause by the sync flops plus two stages; irq_line and irq take three, a compare change more
// Overview of operation
// RULE1: four identical timer, counter and pwm channels are provided.
// RULE2: each channel has a 16-bit counter that only counts down.
// RULE3: software selects each channel's counting clock from several sources.
// RULE4: the comparator can assert on lt, lte, eq, gte or gt against compare.
// RULE5: the period is loaded on start, on timer reset and at terminal count.
// RULE6: free-run, one-shot and enable-gated counting modes exist.
// RULE7: in one-shot mode the counter stops after one full period.
// RULE8: in enable-gated mode the counter steps only while enable is high.
// RULE9: each channel drives compare, terminal count, complement and an irq.
// RULE10: each irq can fire on terminal count, compare true or capture.
// RULE11: a capture input latches the full 16-bit count; a reset input reloads.
// RULE12: a kill input forces the pwm outputs inactive.
// RULE13: complementary outputs are split by a programmable deadband.
// RULE14: terminal count pulses when the count reaches zero, with reload then.
`timescale 1ns/1ps
`include "tcpwm_cfg.svh"
module tcpwm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] clk_src,
  input wire logic [3:0] timer_reset,
  input wire logic [3:0] capture,
  input wire logic [3:0] enable,
  input wire logic [3:0] kill,
  output logic [3:0] cmp_out,
  output logic [3:0] cmp_n_out,
  output logic [3:0] tc_out,
  output logic [3:0] irq_line,
  output logic irq
);
  localparam int N = `TC_INSTANCES;

  // pin side
  logic [19:0] pins_s;
  logic [3:0] src_prev;
  logic [3:0] src_tick;
  logic [3:0] ticks;
  logic [3:0] cmp_w;
  logic [3:0] cmp_n_w;
  logic [3:0] tc_w;
  // register file, one entry per channel
  tc_pkg::ctrl_s ctrl [N];
  logic [15:0] period [N];
  logic [15:0] compare [N];
  logic [7:0] deadband [N];
  logic [N-1:0] start_p;
  // three status bits per channel: tc, compare, capture
  logic [11:0] status;
  logic [11:0] mask;
  logic [11:0] ev_all;
  logic [11:0] status_clr;
  // write side holding registers
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have;
  logic w_have;
  logic do_write;
  logic wr_ok;
  // read side
  logic [31:0] rd_val;
  logic rd_ok;
  logic [31:0] wmask;
  // live count and capture of each channel, for the read decode
  logic [15:0] g_count [N];
  logic [15:0] g_cap [N];

  // all routed inputs pass two flops before use; without them an
  // edge detector could see one pin change twice or not at all
  sync2 #(.W(20)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({kill, enable, capture, timer_reset, clk_src}),
    .q(pins_s)
  );

  // external clock sources become single-cycle ticks on their rising edges
  // limit: a routed clock above half of aclk loses ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev <= 4'h0;
    end else begin
      src_prev <= pins_s[3:0];
    end
  end
  assign src_tick = pins_s[3:0] & ~src_prev;
  // source 0 is aclk itself, 1..3 are routed clocks, see RULE3
  assign ticks = {src_tick[3:1], 1'b1};

  // one channel per instance, see RULE1
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      // configuration flows down the bus, counts and events flow back
      tc_cfg_if bus ();
      assign bus.ctrl = ctrl[gi];
      assign bus.start = start_p[gi];
      assign bus.period = period[gi];
      assign bus.compare = compare[gi];
      assign bus.deadband = deadband[gi];
      // pick this channel's events by its irq select, see RULE10
      assign ev_all[gi*3 +: 3] = bus.events & bus.ctrl.irq_sel;
      tc_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(bus),
        .clk_ticks(ticks),
        .reset_in(pins_s[4+gi]), // see RULE11
        .capture_in(pins_s[8+gi]),
        .enable_in(pins_s[12+gi]),
        .kill_in(pins_s[16+gi]),
        .cmp_out(cmp_w[gi]),
        .cmp_n_out(cmp_n_w[gi]),
        .tc_out(tc_w[gi])
      );
    end
  endgenerate

  // pin outputs registered once more so every top output is a flop
  // this costs one more cycle of lag on cmp_out, cmp_n_out and tc_out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_out <= 4'h0;
      cmp_n_out <= 4'h0;
      tc_out <= 4'h0;
    end else begin
      cmp_out <= cmp_w; // see RULE9
      cmp_n_out <= cmp_n_w; // see RULE13
      tc_out <= tc_w;
    end
  end

  // write channel capture: address and data accepted in either order
  // each half is held here until do_write consumes both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_have <= 1'b0;
      end
    end
  end

  // a new write waits until the previous response has been taken
  assign do_write = aw_have && w_have && !s_axi_bvalid;
  // byte strobes only matter for the status clear
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // ready flags are registered so they come from flops
  // they drop as a half is taken, so no second one slips in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // write decode; a channel window holds 8 words
  // a write outside the map still answers, with slave error
  always_comb begin
    wr_ok = 1'b0;
    if (aw_addr[31:8] != 24'h000000) begin
      wr_ok = 1'b0;
    end else if (aw_addr[7] == 1'b0 && aw_addr[4:2] <= `TC_OFF_DEADBAND) begin
      wr_ok = 1'b1;
    end else if (aw_addr[7:0] == `TC_ADDR_IRQ_STATUS || aw_addr[7:0] == `TC_ADDR_IRQ_MASK ||
                 aw_addr[7:0] == `TC_ADDR_START) begin
      wr_ok = 1'b1;
    end
  end

  // channel configuration registers
  // start_p is a one-cycle strobe; a held level would reload every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N; i++) begin
        ctrl[i] <= tc_pkg::ctrl_s'(12'(`CTRL_RESET));
        period[i] <= `PERIOD_RESET;
        compare[i] <= `COMPARE_RESET;
        deadband[i] <= `DEADBAND_RESET;
      end
      start_p <= '0;
    end else begin
      // strobes fall back low unless a write raises them
      start_p <= '0;
      if (do_write && wr_ok && aw_addr[7] == 1'b0) begin
        case (aw_addr[4:2])
          `TC_OFF_CTRL: begin
            ctrl[aw_addr[6:5]] <= tc_pkg::ctrl_s'(w_data[11:0]);
            // enabling a channel acts as start, which reloads the period
            start_p[aw_addr[6:5]] <= w_data[`CTRL_ENABLE];
          end
          `TC_OFF_PERIOD: period[aw_addr[6:5]] <= w_data[15:0];
          `TC_OFF_COMPARE: compare[aw_addr[6:5]] <= w_data[15:0];
          `TC_OFF_DEADBAND: deadband[aw_addr[6:5]] <= w_data[7:0];
          default: ;
        endcase
      end else if (do_write && aw_addr[7:0] == `TC_ADDR_START) begin
        start_p <= w_data[3:0]; // see RULE5
      end
    end
  end

  // sticky status: set wins over write-one-to-clear
  // so an event in the same cycle as its clear is never lost
  assign status_clr = (do_write && aw_addr[7:0] == `TC_ADDR_IRQ_STATUS) ?
                      (w_data[11:0] & wmask[11:0]) : 12'h000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 12'h000;
      mask <= 12'h000;
    end else begin
      status <= (status & ~status_clr) | ev_all; // see RULE10
      if (do_write && aw_addr[7:0] == `TC_ADDR_IRQ_MASK) begin
        mask <= w_data[11:0];
      end
    end
  end

  // one irq per channel plus the combined line, see RULE9
  // both come from the same masked bits and change together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_line <= 4'h0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        irq_line[i] <= |(status[i*3 +: 3] & mask[i*3 +: 3]);
      end
      irq <= |(status & mask);
    end
  end

  // write response one cycle after both halves are held
  // bresp is slave error for an address outside the map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read decode; live count is readable at any time
  // a running count is read live, so two reads in a row may differ
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[31:8] != 24'h000000) begin
      rd_ok = 1'b0;
    end else if (s_axi_araddr[7] == 1'b0) begin
      case (s_axi_araddr[4:2])
        `TC_OFF_CTRL: rd_val = {20'h00000, ctrl[s_axi_araddr[6:5]]};
        `TC_OFF_PERIOD: rd_val = {16'h0000, period[s_axi_araddr[6:5]]};
        `TC_OFF_COMPARE: rd_val = {16'h0000, compare[s_axi_araddr[6:5]]};
        `TC_OFF_COUNT: rd_val = {16'h0000, g_count[s_axi_araddr[6:5]]};
        `TC_OFF_CAPTURE: rd_val = {16'h0000, g_cap[s_axi_araddr[6:5]]};
        `TC_OFF_DEADBAND: rd_val = {24'h000000, deadband[s_axi_araddr[6:5]]};
        default: rd_ok = 1'b0;
      endcase
    end else if (s_axi_araddr[7:0] == `TC_ADDR_IRQ_STATUS) begin
      rd_val = {20'h00000, status};
    end else if (s_axi_araddr[7:0] == `TC_ADDR_IRQ_MASK) begin
      rd_val = {20'h00000, mask};
    end else if (s_axi_araddr[7:0] == `TC_ADDR_START) begin
      rd_val = 32'h0000_0000;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // gather live count and capture values for reads; reaching into the
  // channel blocks keeps read wiring out of the channel loop
  generate
    for (gi = 0; gi < N; gi++) begin : g_rd
      assign g_count[gi] = g_ch[gi].bus.count;
      assign g_cap[gi] = g_ch[gi].bus.capture;
    end
  endgenerate

  // read channel: the address is taken first, data follow one edge later
  // and hold until rready, so no answer ever precedes its request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1; // idle: ready for the next address
    end
  end
endmodule

// ==== tb/tcpwm_props.sv ====
// Purpose: port-level checks of the four timer channels
// Assumes: one aclk domain, synchronous active-low aresetn
// Notes: attached to tcpwm_top by the bind below
`timescale 1ns/1ps
module tcpwm_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] kill,
  input wire logic [3:0] cmp_out,
  input wire logic [3:0] cmp_n_out,
  input wire logic [3:0] tc_out,
  input wire logic [3:0] irq_line,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a pulse that sticks would count one wrap as many
  a_tc_single: assert property ((tc_out & $past(tc_out)) == 4'h0)
    else $error("terminal count longer than one cycle");
  // kill reaches the pins through two sync flops and two output flops, six cycles is ample
  a_kill_cmp: assert property (kill[3] [*6] |-> !cmp_out[3])
    else $error("compare output alive under kill");
  a_kill_comp: assert property (kill[3] [*6] |-> !cmp_n_out[3])
    else $error("complement output alive under kill");
  a_pair_apart: assert property ((cmp_out & cmp_n_out) == 4'h0)
    else $error("both outputs of a pair active");
  a_irq_or_set: assert property ((|irq_line) [*3] |-> irq)
    else $error("irq low while a channel line is high");
  a_irq_or_clear: assert property (!(|irq_line) [*3] |-> !irq)
    else $error("irq high with all channel lines low");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer withdrawn early");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer withdrawn early");
  c_kill: cover property (kill[3] [*6]);
endmodule

bind tcpwm_top tcpwm_props i_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .kill, .cmp_out, .cmp_n_out, .tc_out,
  .irq_line, .irq);

// ==== tb/route_pins.sv ====
// Purpose: stand-in for the routed clock sources feeding the timers
// Assumes: sources are derived in the aclk domain, so phase is fixed
// Notes: source n (1..3) has a period of 2^(n+1) aclk cycles
`timescale 1ns/1ps
module route_pins (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [3:0] clk_src
);
  logic [3:0] div;
  // free-running divider; fixed phase makes tick spacing exact
  always_ff @(posedge aclk) begin
    if (!aresetn) div <= 4'h0;
    else div <= div + 4'h1;
  end
  assign clk_src = {div[3:1], 1'b0}; // source 0 is aclk itself
endmodule

// ==== tb/timer_counter_pwm16_bench.sv ====
// Purpose: self-checking bench of the four-channel timer block
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes: reads and tc spacing are checked by the monitor from queues
`timescale 1ns/1ps
`include "tcpwm_cfg.svh"
module timer_counter_pwm16_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] clk_src, t_rst, cap, ena, kill, cmp_out, cmp_n_out, tc_out, irq_line;
  logic [65:0] rd_q[$];
  logic [15:0] gap_q[$];
  logic [65:0] e;
  logic [15:0] gap, g, p, c;
  logic [31:0] tc1_cnt;
  int bad_count, checks_done, cyc, seed, r;
  tcpwm_top i_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clk_src, .timer_reset(t_rst), .capture(cap), .enable(ena), .kill, .cmp_out, .cmp_n_out,
    .tc_out, .irq_line, .irq);
  route_pins i_pins (.aclk, .aresetn, .clk_src);
  always #25 aclk = ~aclk;
  task check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task wr(input logic [31:0] a, d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  // read: the expected word, its mask and response go on the queue first
  task rd(input logic [31:0] a, exp, m, input logic [1:0] resp);
    rd_q.push_back({resp, m, exp & m});
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
  endtask
  function logic rel(input int k, input logic [15:0] cnt, cv);
    case (k)
      0: return cnt < cv;
      1: return cnt <= cv;
      2: return cnt == cv;
      3: return cnt >= cv;
      default: return cnt > cv;
    endcase
  endfunction
  // monitor: oldest note is taken off when a read answer or a tc pulse shows
  always @(posedge aclk) begin
    if (rvalid && rready && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      check(rdata & e[63:32], e[31:0]);
      check({30'h0, rresp}, {30'h0, e[65:64]});
    end
    if (bvalid && bready) check({30'h0, bresp}, 32'h0);
    gap <= tc_out[0] ? 16'h1 : gap + 16'h1;
    if (tc_out[0] && gap_q.size() > 0) begin
      g = gap_q.pop_front();
      if (g !== 16'h0) check({16'h0, gap}, {16'h0, g});
    end
    if (tc_out[1]) tc1_cnt <= tc1_cnt + 1;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("BAD %0t: run did not complete", $time);
      results();
    end
  end
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; wdata = 0; araddr = 0; t_rst = 0; cap = 0; ena = 0; kill = 0;
    gap = 0; tc1_cnt = 0; seed = 40;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(32'h00, 32'h0, 32'hFFFF_FFFF, 2'b00);
    rd(32'h04, `PERIOD_RESET, 32'hFFFF, 2'b00);
    rd(32'h08, `COMPARE_RESET, 32'hFFFF, 2'b00);
    rd(32'h14, 32'h0, 32'hFF, 2'b00);
    rd(`TC_ADDR_START, 32'h0, 32'hFFFF_FFFF, 2'b00);
    rd(32'h9C, 32'h0, 32'h0, 2'b10); // unmapped place answers slave error
    $display("test reset values done");
    // every clock source on channel 0, period 9 gives ten ticks between pulses
    wr(32'h04, 32'h9);
    for (int s = 0; s < 4; s++) begin
      wr(32'h00, 32'h0);
      gap_q.push_back(16'h0);
      gap_q.push_back(16'd10 << (s == 0 ? 0 : s + 1));
      wr(32'h00, 32'h101 | (s << 6));
      while (gap_q.size() != 0) @(posedge aclk);
    end
    $display("test clock sources done");
    // one-shot wraps once, a start makes it run once more
    wr(32'h24, 32'h5);
    wr(32'h20, 32'h3);
    repeat (60) @(posedge aclk);
    check(tc1_cnt, 32'h1);
    wr(`TC_ADDR_START, 32'h2);
    repeat (60) @(posedge aclk);
    check(tc1_cnt, 32'h2);
    $display("test one shot done");
    // gated channel 2 holds at period with enable low, reloads on timer reset
    r = $random(seed);
    p = 16'h0100 + {4'h0, r[11:0]};
    wr(32'h44, {16'h0, p});
    wr(32'h40, 32'h405);
    repeat (8) @(posedge aclk);
    rd(32'h4C, {16'h0, p}, 32'hFFFF, 2'b00);
    ena[2] <= 1;
    repeat (30) @(posedge aclk);
    ena[2] <= 0;
    t_rst[2] <= 1;
    repeat (4) @(posedge aclk);
    t_rst[2] <= 0;
    repeat (6) @(posedge aclk);
    rd(32'h4C, {16'h0, p}, 32'hFFFF, 2'b00);
    cap[2] <= 1;
    repeat (6) @(posedge aclk);
    cap[2] <= 0;
    rd(32'h50, {16'h0, p}, 32'hFFFF, 2'b00);
    $display("test gating and capture done");
    // every relation against compare one below, equal and one above the count
    r = $random(seed);
    p = 16'h0100 + {4'h0, r[11:0]};
    wr(32'h64, {16'h0, p});
    for (int k = 0; k < 5; k++) begin
      for (int d = 1; d >= -1; d--) begin
        c = 16'(p + d);
        wr(32'h68, {16'h0, c});
        wr(32'h60, 32'hA05 | (k << 3));
        repeat (8) @(posedge aclk);
        check({31'h0, cmp_out[3]}, {31'h0, rel(k, p, c)});
        check({31'h0, cmp_n_out[3]}, {31'h0, !rel(k, p, c)});
      end
    end
    kill[3] <= 1;
    repeat (8) @(posedge aclk);
    check({30'h0, cmp_out[3], cmp_n_out[3]}, 32'h0);
    kill[3] <= 0;
    // deadband of 64: both outputs stay low after the compare flips
    repeat (4) @(posedge aclk);
    wr(32'h74, 32'h40);
    wr(32'h68, {16'h0, p + 16'h1});
    repeat (8) @(posedge aclk);
    check({30'h0, cmp_out[3], cmp_n_out[3]}, 32'h0);
    repeat (70) @(posedge aclk);
    check({30'h0, cmp_out[3], cmp_n_out[3]}, 32'h1);
    $display("test compare, kill and deadband done");
    // tc, capture and compare events each left a sticky bit
    wr(32'h00, 32'h0);
    wr(32'h40, 32'h0);
    wr(32'h60, 32'h0);
    rd(`TC_ADDR_IRQ_STATUS, 32'h501, 32'hFFF, 2'b00);
    wr(`TC_ADDR_IRQ_MASK, 32'hFFF);
    repeat (4) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    check({28'h0, irq_line}, 32'hD);
    wr(`TC_ADDR_IRQ_MASK, 32'h0);
    repeat (4) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    wr(`TC_ADDR_IRQ_STATUS, 32'hFFF);
    rd(`TC_ADDR_IRQ_STATUS, 32'h0, 32'hFFF, 2'b00);
    repeat (4) @(posedge aclk);
    $display("test interrupts done");
    results();
  end
endmodule
